// ---- serial_link_param_status_regs.sv ----
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "serial_link_defines.svh"
module serial_link_param_status_regs #(
  parameter int LANES = 8,
  parameter int ADDR_W = 16,
  parameter int SAMPLES_PER_FRAME = 2,
  parameter int DENSE_PACKING = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic core_soft_rst,
  input wire logic [LANES-1:0] lane_deskew_in,
  input wire logic lane6_sync_in,
  input wire logic [LANES-1:0] lane_disp_err_in,
  output logic skip_align_sequence,
  output serial_link_pkg::reg_byte_t error_threshold,
  output logic irq
);
  import serial_link_pkg::*;

  localparam int LANE_MAX = 8;

  // configurations the logic cannot serve are refused
  generate
    if (LANES < 1 || LANES > LANE_MAX) begin : g_lanes_chk
      $error("LANES must be 1 to 8");
    end
    if (ADDR_W < 16) begin : g_addr_chk
      $error("ADDR_W must be at least 16");
    end
    if (SAMPLES_PER_FRAME < 1 || SAMPLES_PER_FRAME > 2) begin : g_s_chk
      $error("SAMPLES_PER_FRAME must be 1 or 2");
    end
    if (DENSE_PACKING < 0 || DENSE_PACKING > 1) begin : g_hd_chk
      $error("DENSE_PACKING must be 0 or 1");
    end
  endgenerate

  // fixed link parameters, seen by software only
  localparam logic [4:0] SAMPLES_FIELD = 5'(SAMPLES_PER_FRAME - 1);
  localparam logic DENSE_FIELD = 1'(DENSE_PACKING);

  // bus handshake
  logic ack_q;
  logic access;
  logic wr_fire;
  logic rd_take;
  reg_index_t index;
  logic aligned;
  reg_sel_t sel;
  reg_byte_t wbyte;

  // stored registers
  logic [4:0] samples_q;
  logic dense_q;
  reg_byte_t spare_a_q;
  reg_byte_t spare_b_q;
  reg_byte_t sum_q;
  reg_byte_t thresh_q;
  reg_byte_t ctrl_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_stat_d;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [31:0] readdata_q;
  reg_byte_t rd_byte;

  // lane status
  logic [LANES-1:0] deskew_sync;
  logic sync6_sync;
  logic [LANES-1:0] disp_sync;
  logic [LANES-1:0] disp_flag;
  reg_byte_t align_q;
  reg_byte_t align_d;
  reg_byte_t disp_q;
  reg_byte_t disp_d;
  logic [`IRQ_W-1:0] events;

  // ---------------------------------------------------------------
  // bus slave: one wait cycle for every access
  // ---------------------------------------------------------------

  // waitrequest drops one cycle after the request rises
  assign access = read | write;
  assign waitrequest = access & ~ack_q;
  assign wr_fire = write & ack_q;
  assign rd_take = read & ~ack_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  // word addressing; a byte offset inside a word is unmapped
  assign index = address[15:2];
  assign aligned = (address[1:0] == 2'b00);
  assign wbyte = writedata[7:0];

  // index decode
  always_comb begin
    sel = SEL_NONE;
    if (aligned) begin
      case (index)
        `IDX_SAMPLES: sel = SEL_SAMPLES;
        `IDX_DENSITY: sel = SEL_DENSITY;
        `IDX_SPARE_A: sel = SEL_SPARE_A;
        `IDX_SPARE_B: sel = SEL_SPARE_B;
        `IDX_SUM: sel = SEL_SUM;
        `IDX_ALIGN: sel = SEL_ALIGN;
        `IDX_DISP: sel = SEL_DISP;
        `IDX_THRESH: sel = SEL_THRESH;
        `IDX_CTRL: sel = SEL_CTRL;
        `IDX_IRQ_STAT: sel = SEL_IRQ_STAT;
        `IDX_IRQ_MASK: sel = SEL_IRQ_MASK;
        default: sel = SEL_NONE;
      endcase
    end
  end

  // a write needs lane 0 enabled; upper lanes hold nothing
  function automatic logic hit(input reg_sel_t which);
    hit = wr_fire && byteenable[0] && (sel == which);
  endfunction

  // ---------------------------------------------------------------
  // link parameter set
  // ---------------------------------------------------------------

  // read-only fields loaded from the build parameters
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      samples_q <= `RST_SAMPLES;
      dense_q <= `RST_DENSE;
    end else begin
      samples_q <= SAMPLES_FIELD;
      dense_q <= DENSE_FIELD;
    end
  end

  // spare bytes; writes outside soft reset still land but are flagged
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      spare_a_q <= `RST_SPARE;
      spare_b_q <= `RST_SPARE;
    end else begin
      if (hit(SEL_SPARE_A)) begin
        spare_a_q <= wbyte;
      end
      if (hit(SEL_SPARE_B)) begin
        spare_b_q <= wbyte;
      end
    end
  end

  // parameter sum is stored as written, never recomputed here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sum_q <= `RST_SUM;
    end else if (hit(SEL_SUM)) begin
      sum_q <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------

  // threshold and skip setting steer the lane logic
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      thresh_q <= `RST_THRESH;
      ctrl_q <= `RST_CTRL;
    end else begin
      if (hit(SEL_THRESH)) begin
        thresh_q <= wbyte;
      end
      if (hit(SEL_CTRL)) begin
        ctrl_q <= {7'h00, wbyte[`CTRL_SKIP_BIT]};
      end
    end
  end

  assign error_threshold = thresh_q;
  assign skip_align_sequence = ctrl_q[`CTRL_SKIP_BIT];

  // ---------------------------------------------------------------
  // lane status
  // ---------------------------------------------------------------

  // lane levels come from the link side and are resynchronised
  bit_sync #(
    .WIDTH(LANES)
  ) u_deskew_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(lane_deskew_in),
    .q(deskew_sync)
  );

  bit_sync #(
    .WIDTH(1)
  ) u_sync6_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(lane6_sync_in),
    .q(sync6_sync)
  );

  bit_sync #(
    .WIDTH(LANES)
  ) u_disp_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(lane_disp_err_in),
    .q(disp_sync)
  );

  // per-lane counters; core soft reset restarts the counts
  generate
    for (genvar i = 0; i < LANE_MAX; i++) begin : g_lane
      if (i < LANES) begin : g_used
        lane_disp_counter u_cnt (
          .clock(clock),
          .sys_rst(sys_rst),
          .clear(core_soft_rst),
          .err_level(disp_sync[i]),
          .threshold(thresh_q),
          .flag_q(disp_flag[i])
        );
        assign disp_d[i] = disp_flag[i];
        if (i == `SYNC_LANE) begin : g_sync
          assign align_d[i] = sync6_sync;
        end else begin : g_desk
          assign align_d[i] = deskew_sync[i];
        end
      end else begin : g_unused
        assign disp_d[i] = 1'b0;
        assign align_d[i] = 1'b0;
      end
    end
  endgenerate

  // status copies; a held soft reset shows no alignment
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      align_q <= `RST_STATUS;
      disp_q <= `RST_STATUS;
    end else begin
      align_q <= core_soft_rst ? `RST_STATUS : align_d;
      disp_q <= disp_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------

  // alignment loss is not an event while the skip setting is on,
  // since the flags mean nothing then
  always_comb begin
    events = '0;
    events[`IRQ_DISP_BIT] = |(disp_d & ~disp_q);
    events[`IRQ_ALIGN_BIT] = ~skip_align_sequence &
      |(align_q & ~align_d) & ~core_soft_rst;
    events[`IRQ_PWRITE_BIT] = ~core_soft_rst &
      (hit(SEL_SPARE_A) | hit(SEL_SPARE_B) | hit(SEL_SUM));
  end

  // write one to clear; a new event in the same cycle wins
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (hit(SEL_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~wbyte[`IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | events;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= `RST_IRQ;
      irq_mask_q <= `RST_IRQ;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (hit(SEL_IRQ_MASK)) begin
        irq_mask_q <= wbyte[`IRQ_W-1:0];
      end
    end
  end

  // level output, high while any unmasked bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // unmapped and reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      SEL_SAMPLES: rd_byte[`SAMPLES_MSB:0] = samples_q;
      SEL_DENSITY: begin
        rd_byte[`DENSE_BIT] = dense_q;
        rd_byte[`CTRLW_MSB:0] = `RST_CTRLW;
      end
      SEL_SPARE_A: rd_byte = spare_a_q;
      SEL_SPARE_B: rd_byte = spare_b_q;
      SEL_SUM: rd_byte = sum_q;
      SEL_ALIGN: rd_byte = align_q;
      SEL_DISP: rd_byte = disp_q;
      SEL_THRESH: rd_byte = thresh_q;
      SEL_CTRL: rd_byte = ctrl_q;
      SEL_IRQ_STAT: rd_byte[`IRQ_W-1:0] = irq_stat_q;
      SEL_IRQ_MASK: rd_byte[`IRQ_W-1:0] = irq_mask_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // captured in the wait cycle, stands until the next read
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_q <= 32'h00000000;
    end else if (rd_take) begin
      readdata_q <= {24'h000000, rd_byte};
    end
  end

  assign readdata = readdata_q;
endmodule

// ---- serial_link_defines.svh ----
`ifndef SERIAL_LINK_DEFINES_SVH
`define SERIAL_LINK_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_SAMPLES 14'h0459
`define IDX_DENSITY 14'h045A
`define IDX_SPARE_A 14'h045B
`define IDX_SPARE_B 14'h045C
`define IDX_SUM 14'h045D
`define IDX_ALIGN 14'h046C
`define IDX_DISP 14'h046D
`define IDX_THRESH 14'h0480
`define IDX_CTRL 14'h0481
`define IDX_IRQ_STAT 14'h0482
`define IDX_IRQ_MASK 14'h0483

// field positions
`define SAMPLES_MSB 4
`define DENSE_BIT 7
`define CTRLW_MSB 4
`define SYNC_LANE 6
`define CTRL_SKIP_BIT 0
`define IRQ_DISP_BIT 0
`define IRQ_ALIGN_BIT 1
`define IRQ_PWRITE_BIT 2
`define IRQ_W 3

// reset values
`define RST_SAMPLES 5'h01
`define RST_DENSE 1'h1
`define RST_CTRLW 5'h00
`define RST_SPARE 8'h00
`define RST_SUM 8'h00
`define RST_STATUS 8'h00
`define RST_THRESH 8'h01
`define RST_CTRL 8'h00
`define RST_IRQ 3'h0
`endif

// ---- serial_link_pkg.sv ----
package serial_link_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [13:0] reg_index_t;
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_SAMPLES,
    SEL_DENSITY,
    SEL_SPARE_A,
    SEL_SPARE_B,
    SEL_SUM,
    SEL_ALIGN,
    SEL_DISP,
    SEL_THRESH,
    SEL_CTRL,
    SEL_IRQ_STAT,
    SEL_IRQ_MASK
  } reg_sel_t;
endpackage

// ---- bit_sync.sv ----
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("bit_sync needs at least one bit");
    end
  endgenerate

  // two stages; only the second stage is read outside
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- lane_disp_counter.sv ----
`timescale 1ns/1ps
module lane_disp_counter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic err_level,
  input wire serial_link_pkg::reg_byte_t threshold,
  output logic flag_q
);
  import serial_link_pkg::*;

  reg_byte_t count_q;
  logic prev_q;
  logic err_rise;

  // one error per rising edge of the synchronised level
  assign err_rise = err_level & ~prev_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= err_level;
    end
  end

  // saturate so a noisy lane never wraps back below threshold
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 8'h00;
    end else if (clear) begin
      count_q <= 8'h00;
    end else if (err_rise && count_q != 8'hFF) begin
      count_q <= count_q + 8'h01;
    end
  end

  // live compare, registered for a clean read
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (count_q >= threshold);
    end
  end
endmodule

// ---- serial_link_sva.sv ----
`timescale 1ns/1ps
`include "serial_link_defines.svh"
module serial_link_chk #(
  parameter int LANES = 8,
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic core_soft_rst,
  input wire logic [LANES-1:0] lane_deskew_in,
  input wire logic lane6_sync_in,
  input wire logic [LANES-1:0] lane_disp_err_in,
  input wire logic skip_align_sequence,
  input wire serial_link_pkg::reg_byte_t error_threshold,
  input wire logic irq
);
  import serial_link_pkg::*;
  localparam logic [ADDR_W-1:0] A_SMP = ADDR_W'({`IDX_SAMPLES, 2'h0});
  localparam logic [ADDR_W-1:0] A_DNS = ADDR_W'({`IDX_DENSITY, 2'h0});
  localparam logic [ADDR_W-1:0] A_ALN = ADDR_W'({`IDX_ALIGN, 2'h0});
  localparam logic [ADDR_W-1:0] A_DSP = ADDR_W'({`IDX_DISP, 2'h0});
  localparam logic [ADDR_W-1:0] A_THR = ADDR_W'({`IDX_THRESH, 2'h0});
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({`IDX_CTRL, 2'h0});
  localparam logic [ADDR_W-1:0] A_MSK = ADDR_W'({`IDX_IRQ_MASK, 2'h0});
  logic [2:0] srst_q;
  logic rd_ok;
  logic wr_ok;
  // age of soft reset; a forced-zero read only counts once it has settled
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      srst_q <= 3'h0;
    end else if (!core_soft_rst) begin
      srst_q <= 3'h0;
    end else if (srst_q != 3'h7) begin
      srst_q <= srst_q + 3'h1;
    end
  end
  // accepted transfers
  assign rd_ok = read && !waitrequest;
  assign wr_ok = write && !waitrequest && byteenable[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait lasted more than one cycle");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised while bus idle");
  AST_SAMPLES: assert property (rd_ok && address == A_SMP |->
    readdata == 32'h0000_0001) else $error("samples field wrong");
  AST_DENSE: assert property (rd_ok && address == A_DNS |->
    readdata == 32'h0000_0080) else $error("density byte wrong");
  AST_UPPER: assert property (rd_ok |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_UNMAP: assert property (rd_ok && address[1:0] != 2'h0 |->
    readdata == 32'h0) else $error("misaligned read not zero");
  AST_ALIGN_SRST: assert property (rd_ok && address == A_ALN &&
    srst_q >= 3'h3 |-> readdata == 32'h0) else $error("align not cleared");
  AST_THRESH_WR: assert property (wr_ok && address == A_THR |=>
    error_threshold == $past(writedata[7:0])) else $error("threshold stale");
  AST_SKIP_WR: assert property (wr_ok && address == A_CTL |=>
    skip_align_sequence == $past(writedata[0])) else $error("skip stale");
  AST_MASK_OFF: assert property (wr_ok && address == A_MSK &&
    writedata[2:0] == 3'h0 |=> !irq) else $error("irq with mask clear");
  COV_DISP: cover property (rd_ok && address == A_DSP && readdata != 32'h0);
  COV_IRQ: cover property (irq);
  COV_SKIP: cover property (skip_align_sequence);
endmodule

// ---- lane_tx_model.sv ----
`timescale 1ns/1ps
module lane_tx_model (
  input wire logic clock,
  output logic [7:0] deskew,
  output logic sync6,
  output logic [7:0] disp_err
);
  initial begin
    deskew = 8'h00;
    sync6 = 1'b0;
    disp_err = 8'h00;
  end
  // status levels move just after an edge, unrelated to bus traffic
  task show(input logic [7:0] d, input logic s);
    @(posedge clock);
    deskew <= d;
    sync6 <= s;
  endtask
  // nibble i gives lane i's error count, at most 8; 2 high 2 low so none is lost
  task burst(input logic [31:0] n);
    logic [7:0] m;
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 8; i++) m[i] = n[4*i +: 4] > k;
      @(posedge clock);
      disp_err <= m;
      repeat (2) @(posedge clock);
      disp_err <= 8'h00;
      @(posedge clock);
    end
  endtask
endmodule

// ---- serial_link_param_status_regs_tb.sv ----
`timescale 1ns/1ps
`include "serial_link_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, (g), (e)); end end
module serial_link_param_status_regs_tb;
  import serial_link_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic core_soft_rst = 1'b0;
  logic [15:0] address = 16'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata, expd, seed = 32'hB414;
  logic [31:0] q[$];
  logic waitrequest, skip_align_sequence, irq, sync6;
  logic [7:0] deskew, disp_err, sa, sb, sm;
  reg_byte_t error_threshold;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #2.5 clock = ~clock;
  serial_link_param_status_regs DUT (.clock(clock), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .core_soft_rst(core_soft_rst), .lane_deskew_in(deskew),
    .lane6_sync_in(sync6), .lane_disp_err_in(disp_err),
    .skip_align_sequence(skip_align_sequence),
    .error_threshold(error_threshold), .irq(irq));
  lane_tx_model MDL (.clock(clock), .deskew(deskew), .sync6(sync6),
    .disp_err(disp_err));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] ad(input reg_index_t i);
    return {i, 2'h0};
  endfunction
  task summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one Avalon transfer, held until waitrequest is seen low at an edge
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {seed[31:8], d};
    @(posedge clock iff waitrequest === 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    acc(1'b0, a, 8'h00);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  // read data is taken at the edge that ends the wait
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      expd = q.size() ? q.pop_front() : 32'hXXXX_XXXX;
      `CHK(readdata, expd)
    end
  end
  // a hang ends the run as a failure
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd(ad(`IDX_SAMPLES), 8'h01);
    rd(ad(`IDX_DENSITY), 8'h80);
    rd(ad(`IDX_SPARE_A), 8'h00);
    rd(ad(`IDX_SPARE_B), 8'h00);
    rd(ad(`IDX_SUM), 8'h00);
    rd(ad(`IDX_ALIGN), 8'h00);
    rd(ad(`IDX_DISP), 8'h00);
    rd(16'h1301, 8'h00);
    $display("reset values done");
    seed = xs(seed);
    sa = seed[7:0];
    seed = xs(seed);
    sb = seed[7:0];
    sm = 8'h81 + sa + sb; // only this slice's share of the sum
    core_soft_rst <= 1'b1;
    wr(ad(`IDX_SPARE_A), sa);
    wr(ad(`IDX_SPARE_B), sb);
    wr(ad(`IDX_SUM), sm);
    wr(ad(`IDX_DENSITY), 8'h00);
    wr(ad(`IDX_IRQ_MASK), 8'h07);
    core_soft_rst <= 1'b0;
    rd(ad(`IDX_SPARE_A), sa);
    rd(ad(`IDX_SPARE_B), sb);
    rd(ad(`IDX_SUM), sm);
    rd(ad(`IDX_DENSITY), 8'h80);
    rd(ad(`IDX_IRQ_STAT), 8'h00);
    `CHK(irq, 1'b0)
    wr(ad(`IDX_SPARE_B), sb);
    rd(ad(`IDX_IRQ_STAT), 8'h04);
    `CHK(irq, 1'b1)
    wr(ad(`IDX_IRQ_STAT), 8'h04);
    rd(ad(`IDX_IRQ_STAT), 8'h00);
    `CHK(irq, 1'b0)
    $display("config and irq done");
    seed = xs(seed);
    MDL.show(seed[7:0], seed[8]);
    repeat (5) @(posedge clock);
    rd(ad(`IDX_ALIGN), {seed[7], seed[8], seed[5:0]});
    wr(ad(`IDX_CTRL), 8'h01);
    MDL.show(8'h00, 1'b0);
    repeat (5) @(posedge clock);
    rd(ad(`IDX_IRQ_STAT), 8'h00);
    rd(ad(`IDX_CTRL), 8'h01);
    wr(ad(`IDX_CTRL), 8'h00);
    MDL.show(8'hFF, 1'b1);
    core_soft_rst <= 1'b1;
    repeat (5) @(posedge clock);
    rd(ad(`IDX_ALIGN), 8'h00);
    core_soft_rst <= 1'b0;
    $display("alignment done");
    wr(ad(`IDX_THRESH), 8'h03);
    MDL.burst(32'h5324_3210);
    repeat (6) @(posedge clock);
    rd(ad(`IDX_DISP), 8'hD8);
    rd(ad(`IDX_IRQ_STAT), 8'h01);
    wr(ad(`IDX_THRESH), 8'h00);
    repeat (4) @(posedge clock);
    rd(ad(`IDX_DISP), 8'hFF);
    core_soft_rst <= 1'b1;
    wr(ad(`IDX_THRESH), 8'h01);
    repeat (4) @(posedge clock);
    core_soft_rst <= 1'b0;
    rd(ad(`IDX_DISP), 8'h00);
    $display("disparity done");
    MDL.show(8'h00, 1'b0);
    repeat (5) @(posedge clock);
    rd(ad(`IDX_IRQ_STAT), 8'h03);
    `CHK(irq, 1'b1)
    wr(ad(`IDX_IRQ_MASK), 8'h00);
    @(posedge clock);
    `CHK(irq, 1'b0)
    $display("irq mask done");
    repeat (2) @(posedge clock);
    summarize();
  end
endmodule
bind serial_link_param_status_regs serial_link_chk #(.LANES(LANES),
  .ADDR_W(ADDR_W)) CHKR (.clock(clock), .sys_rst(sys_rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .core_soft_rst(core_soft_rst), .lane_deskew_in(lane_deskew_in),
  .lane6_sync_in(lane6_sync_in), .lane_disp_err_in(lane_disp_err_in),
  .skip_align_sequence(skip_align_sequence),
  .error_threshold(error_threshold), .irq(irq));
